// ===== hw/dmacc_core.sv
// DMA channel control core: channel and operation registers, enable check, counting
`timescale 1ns/1ps
module dmacc_core
  import dmacc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        standby,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  input  wire logic [3:0]  xfer_req,
  input  wire logic        addr_error,
  input  wire logic        nmi,
  output logic [3:0]       unit_grant,
  output logic [3:0]       unit_word,
  output logic [3:0]       burst_mode,
  output logic [3:0]       transfer_end_interrupt
);
  logic [3:0]  channel_enable_q;
  logic [3:0]  transfer_end_flag_q;
  logic [3:0]  completion_irq_enable_q;
  logic [3:0]  transfer_size_q;
  logic [3:0]  bus_mode_select_q;
  logic [3:0]  auto_req_q;
  logic [15:0] transfer_count_q [DMACC_NCH];
  logic [3:0]  tend_seen_q;
  logic [1:0]  prio_q;
  logic        address_error_flag_q;
  logic        nonmaskable_event_flag_q;
  logic        aerr_seen_q;
  logic        nonmaskable_event_flag_seen_q;
  logic        master_enable_q;
  logic [1:0]  last_q;
  logic [3:0]  runnable;
  logic [3:0]  want;
  logic [3:0]  grant_d;
  logic        clr_all;

  function automatic logic [1:0] order_ch(input logic [1:0] mode, input logic [1:0] last,
                                          input logic [1:0] pos);
    logic [1:0] base;
    base = 2'd0;
    case (mode)
      DMACC_PR_FIX0:  base = (pos == 2'd0) ? 2'd0 : 2'(4 - pos);
      DMACC_PR_FIX1:  base = (pos == 2'd0) ? 2'd1 : ((pos == 2'd3) ? 2'd0 : 2'(4 - pos));
      DMACC_PR_RR:    base = (pos == 2'd0) ? 2'd0 : 2'(4 - pos);
      default:        base = 2'(3 - pos);
    endcase
    if (mode[1]) begin
      base = 2'(base + last);
    end
    order_ch = base;
  endfunction

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] base, output int ch);
    logic hit;
    hit = 1'b0;
    ch  = 0;
    for (int i = 0; i < DMACC_NCH; i++) begin
      if (a == 8'(base + 8'(i) * DMACC_STEP_OFF)) begin
        hit = 1'b1;
        ch  = i;
      end
    end
    is_reg = hit;
  endfunction

  assign clr_all = standby;

  // Channel enabled only when no blocking flag stands
  always_comb begin
    for (int i = 0; i < DMACC_NCH; i++) begin
      runnable[i] = channel_enable_q[i] & master_enable_q & ~transfer_end_flag_q[i] // R8
                    & ~address_error_flag_q & ~nonmaskable_event_flag_q // R16
                    & ~addr_error & ~nmi; // R21
      want[i] = runnable[i] & (auto_req_q[i] | xfer_req[i]); // R9 R10
    end
  end

  // One grant per cycle; walk the priority order
  always_comb begin
    logic [1:0] c;
    logic       found;
    c       = 2'd0;
    found   = 1'b0;
    grant_d = 4'h0;
    for (int p = 0; p < DMACC_NCH; p++) begin
      c = order_ch(prio_q, last_q, 2'(p)); // R15
      if (!found && want[c]) begin
        grant_d[c] = 1'b1;
        found      = 1'b1;
      end
    end
  end

  // Rotation point; pin round-robin starts with ch3 top after reset
  always_ff @(posedge clk) begin
    if (!rstn || clr_all) begin
      last_q <= 2'd0;
    end else begin
      for (int i = 0; i < DMACC_NCH; i++) begin
        if (grant_d[i] && prio_q[1]) begin
          // Offset chosen so the granted channel lands at the lowest slot
          last_q <= (prio_q == DMACC_PR_RR) ? 2'(i - 1) : 2'(i);
        end
      end
    end
  end

  // Channel control bits
  always_ff @(posedge clk) begin
    int ch;
    ch = 0;
    if (!rstn || clr_all) begin
      channel_enable_q        <= 4'h0; // R12
      completion_irq_enable_q <= 4'h0;
      transfer_size_q         <= 4'h0; // R2
      bus_mode_select_q       <= 4'h0; // R1
      auto_req_q              <= 4'h0;
    end else if (wr && is_reg(addr, DMACC_CHANNEL_CONTROL_OFF0, ch)) begin
      channel_enable_q[ch]        <= wdata[DMACC_B_ENABLE]; // R11
      completion_irq_enable_q[ch] <= wdata[DMACC_B_IRQEN];
      transfer_size_q[ch]         <= wdata[DMACC_B_SIZE]; // R2
      bus_mode_select_q[ch]       <= wdata[DMACC_B_BURST]; // R1
      auto_req_q[ch]              <= wdata[DMACC_B_AUTO];
    end
  end

  // Transfer count: one unit per grant
  always_ff @(posedge clk) begin
    int ch;
    ch = 0;
    if (!rstn || clr_all) begin
      for (int i = 0; i < DMACC_NCH; i++) begin
        transfer_count_q[i] <= DMACC_TCNT_RST;
      end
    end else begin
      for (int i = 0; i < DMACC_NCH; i++) begin
        if (grant_d[i]) begin
          transfer_count_q[i] <= transfer_count_q[i] - 16'h0001; // R20
        end
      end
      if (wr && is_reg(addr, DMACC_TCNT_OFF0, ch)) begin
        transfer_count_q[ch] <= wdata;
      end
    end
  end

  // Transfer-end flag: set wins over clear; aborts never set it
  always_ff @(posedge clk) begin
    int ch;
    ch = 0;
    if (!rstn || clr_all) begin
      transfer_end_flag_q <= 4'h0; // R12
      tend_seen_q         <= 4'h0;
    end else begin
      if (rd && is_reg(addr, DMACC_CHANNEL_CONTROL_OFF0, ch)) begin
        tend_seen_q[ch] <= transfer_end_flag_q[ch];
      end
      if (wr && is_reg(addr, DMACC_CHANNEL_CONTROL_OFF0, ch) && !wdata[DMACC_B_TEND]
          && tend_seen_q[ch]) begin
        transfer_end_flag_q[ch] <= 1'b0; // R7
        tend_seen_q[ch]         <= 1'b0;
      end
      for (int i = 0; i < DMACC_NCH; i++) begin
        if (grant_d[i] && transfer_count_q[i] == 16'h0001) begin
          transfer_end_flag_q[i] <= 1'b1; // R5 R6
        end
      end
    end
  end

  // Operation register
  always_ff @(posedge clk) begin
    if (!rstn || clr_all) begin
      prio_q          <= DMACC_OPCR_RST[DMACC_B_PRIO +: 2]; // R13
      master_enable_q <= DMACC_OPCR_RST[DMACC_B_MEN];
    end else if (wr && addr == DMACC_OPCR_OFF) begin
      prio_q          <= wdata[DMACC_B_PRIO +: 2]; // R15
      master_enable_q <= wdata[DMACC_B_MEN]; // R19
    end
  end

  // Error flags: hardware set wins over software clear
  always_ff @(posedge clk) begin
    if (!rstn || clr_all) begin
      address_error_flag_q     <= 1'b0;
      nonmaskable_event_flag_q <= 1'b0;
      aerr_seen_q              <= 1'b0;
      nonmaskable_event_flag_seen_q              <= 1'b0;
    end else begin
      if (rd && addr == DMACC_OPCR_OFF) begin
        aerr_seen_q <= address_error_flag_q;
        nonmaskable_event_flag_seen_q <= nonmaskable_event_flag_q;
      end
      if (wr && addr == DMACC_OPCR_OFF) begin
        if (!wdata[DMACC_B_AERR] && aerr_seen_q) begin
          address_error_flag_q <= 1'b0; // R17
          aerr_seen_q          <= 1'b0;
        end
        if (!wdata[DMACC_B_NONMASKABLE_EVENT_FLAG] && nonmaskable_event_flag_seen_q) begin
          nonmaskable_event_flag_q <= 1'b0; // R18
          nonmaskable_event_flag_seen_q              <= 1'b0;
        end
      end
      if (addr_error) begin
        address_error_flag_q <= 1'b1; // R16
      end
      if (nmi) begin
        nonmaskable_event_flag_q <= 1'b1; // R18
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    int ch;
    ch = 0;
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (rd && is_reg(addr, DMACC_CHANNEL_CONTROL_OFF0, ch)) begin
      rdata <= {10'h000, auto_req_q[ch], bus_mode_select_q[ch], transfer_size_q[ch],
                completion_irq_enable_q[ch], transfer_end_flag_q[ch], channel_enable_q[ch]};
    end else if (rd && is_reg(addr, DMACC_TCNT_OFF0, ch)) begin
      rdata <= transfer_count_q[ch];
    end else if (rd && addr == DMACC_OPCR_OFF) begin
      rdata <= {6'h00, prio_q, 5'h00, address_error_flag_q, // R14
                nonmaskable_event_flag_q, master_enable_q} & DMACC_OPCR_MASK;
    end else begin
      rdata <= 16'h0000;
    end
  end

  // Registered outputs toward the bus engine and interrupt controller
  always_ff @(posedge clk) begin
    if (!rstn || clr_all) begin
      unit_grant             <= 4'h0; // R12
      unit_word              <= 4'h0;
      burst_mode             <= 4'h0;
      transfer_end_interrupt <= 4'h0;
    end else begin
      unit_grant             <= grant_d;
      unit_word              <= transfer_size_q;
      burst_mode             <= bus_mode_select_q;
      transfer_end_interrupt <= completion_irq_enable_q & transfer_end_flag_q; // R4 R22
    end
  end
endmodule

// ===== hw/dmacc_pkg.sv
// Constants and types for the DMA channel control core
// Behaviour
// R1: Bus mode bit 4: 0 cycle-steal, 1 burst; resets to cycle-steal.
// R2: Transfer size bit 3: 0 byte, 1 word; resets to byte.
// R3: Software selects byte size for byte-only peripherals.
// R4: Interrupt enable set raises transfer-end interrupt when transfer-end flag sets.
// R5: Transfer-end flag sets when transfer count reaches zero normally.
// R6: Transfer-end flag stays clear on NMI, address error or enable clear abort.
// R7: Transfer-end flag clears by writing 0 after reading 1; writing 1 ignored.
// R8: Channel enable does not start transfer while transfer-end flag is 1.
// R9: Auto-request starts once both enables set and no blocking flag.
// R10: Peripheral or external mode transfers only on request while enabled.
// R11: Clearing channel enable stops that channel's transfer.
// R12: Channel control bits return to 0 on reset and standby.
// R13: Operation register is 16-bit read/write, zero on reset and standby.
// R14: Operation bits 15-10 and 7-3 read 0; software writes 0.
// R15: Priority field selects fixed, fixed, round-robin or pin round-robin order.
// R16: Address error sets flag; while set no channel is enabled.
// R17: Address error flag clears by 0 write after reading 1.
// R18: NMI sets its flag, blocks channels, clears by 0 after read 1.
// R19: Clearing master enable aborts all channel transfers immediately.
// R20: Each accepted request moves one unit and decrements count by 1.
// R21: Address error or NMI aborts any ongoing transfer.
// R22: Interrupt stays high while interrupt enable and transfer-end flag are 1.
package dmacc_pkg;
  localparam int          DMACC_NCH        = 4;
  localparam logic [7:0]  DMACC_CHANNEL_CONTROL_OFF0  = 8'h00;
  localparam logic [7:0]  DMACC_TCNT_OFF0  = 8'h10;
  localparam logic [7:0]  DMACC_OPCR_OFF   = 8'h20;
  localparam logic [7:0]  DMACC_STEP_OFF   = 8'h04;
  localparam int          DMACC_B_ENABLE   = 0;
  localparam int          DMACC_B_TEND     = 1;
  localparam int          DMACC_B_IRQEN    = 2;
  localparam int          DMACC_B_SIZE     = 3;
  localparam int          DMACC_B_BURST    = 4;
  localparam int          DMACC_B_AUTO     = 5;
  localparam int          DMACC_B_MEN      = 0;
  localparam int          DMACC_B_NONMASKABLE_EVENT_FLAG     = 1;
  localparam int          DMACC_B_AERR     = 2;
  localparam int          DMACC_B_PRIO     = 8;
  localparam logic [15:0] DMACC_CHANNEL_CONTROL_RST   = 16'h0000;
  localparam logic [15:0] DMACC_OPCR_RST   = 16'h0000;
  localparam logic [15:0] DMACC_TCNT_RST   = 16'h0000;
  localparam logic [15:0] DMACC_OPCR_MASK  = 16'h0307;
  typedef enum logic [1:0] {
    DMACC_PR_FIX0  = 2'b00,
    DMACC_PR_FIX1  = 2'b01,
    DMACC_PR_RR    = 2'b10,
    DMACC_PR_PINRR = 2'b11
  } dmacc_prio_t;
endpackage

// ===== testbench/dmacc_core_chk.sv
// Port checker for the DMA channel control core
`timescale 1ns/1ps
module dmacc_core_chk
  import dmacc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        standby,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic [3:0]  xfer_req,
  input wire logic        addr_error,
  input wire logic        nmi,
  input wire logic [3:0]  unit_grant,
  input wire logic [3:0]  unit_word,
  input wire logic [3:0]  burst_mode,
  input wire logic [3:0]  transfer_end_interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Abort must hold off the grant that was already being decided
  sequence s_quiet; (unit_grant == 4'h0)[*3]; endsequence
  sequence s_op_rd; rd && addr == DMACC_OPCR_OFF; endsequence
  sequence s_ch_rd; rd && addr == DMACC_CHANNEL_CONTROL_OFF0; endsequence
  property p_stby_clr; standby |=> {unit_grant, unit_word, burst_mode} == 12'h000; endproperty
  a_stby_clr: assert property (p_stby_clr) else $error("standby left state");
  property p_nmi_stop; $rose(nmi) |=> s_quiet; endproperty
  a_nmi_stop: assert property (p_nmi_stop) else $error("grant after nmi");
  property p_aerr_stop; $rose(addr_error) |=> s_quiet; endproperty
  a_aerr_stop: assert property (p_aerr_stop) else $error("grant after error");
  property p_op_rsv; s_op_rd |=> (rdata & ~DMACC_OPCR_MASK) == 16'h0000; endproperty
  a_op_rsv: assert property (p_op_rsv) else $error("reserved bits set");
  property p_mode; s_ch_rd |=> rdata[4:3] == {burst_mode[0], unit_word[0]}; endproperty
  a_mode: assert property (p_mode) else $error("mode pins differ");
  property p_irq; s_ch_rd |=> transfer_end_interrupt[0] == (rdata[1] & rdata[2]); endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
  property p_men_off; wr && addr == DMACC_OPCR_OFF && !wdata[0] |-> ##2 unit_grant == 4'h0;
  endproperty
  a_men_off: assert property (p_men_off) else $error("grant after master off");
  property p_one; $onehot0(unit_grant); endproperty
  a_one: assert property (p_one) else $error("two grants");
endmodule
bind dmacc_core dmacc_core_chk u_chk (.clk(clk), .rstn(rstn), .standby(standby), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .xfer_req(xfer_req),
  .addr_error(addr_error), .nmi(nmi), .unit_grant(unit_grant), .unit_word(unit_word),
  .burst_mode(burst_mode), .transfer_end_interrupt(transfer_end_interrupt));

// ===== testbench/dmacc_core_tb.sv
// Self-checking bench for the DMA channel control core
`timescale 1ns/1ps
module dmacc_core_tb import dmacc_pkg::*;;
  logic        clk = 0, rstn = 0, standby = 0, wr = 0, rd = 0, nmi = 0, addr_error = 0, arm = 0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [3:0]  unit_grant, unit_word, burst_mode, transfer_end_interrupt, first = 4'h0;
  logic        req1, req2;
  int          n_mismatch = 0, n_compared = 0, cycles = 0, gcnt [4] = '{default: 0};
  always #50 clk = ~clk;
  dmacc_core dut (.clk(clk), .rstn(rstn), .standby(standby), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .xfer_req({1'b0, req2, req1, 1'b0}),
    .addr_error(addr_error), .nmi(nmi), .unit_grant(unit_grant), .unit_word(unit_word),
    .burst_mode(burst_mode), .transfer_end_interrupt(transfer_end_interrupt));
  dmacc_req_src #(.GAP(0)) src1 (.clk(clk), .rstn(rstn), .arm(arm), .grant(unit_grant[1]),
    .req(req1));
  dmacc_req_src #(.GAP(3)) src2 (.clk(clk), .rstn(rstn), .arm(arm), .grant(unit_grant[2]),
    .req(req2));
  task automatic close_out();
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    for (int i = 0; i < 4; i++) if (unit_grant[i]) gcnt[i] <= gcnt[i] + 1;
    if (first == 4'h0) first <= unit_grant;
    if (cycles == 2000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Strobe drops at the sampling edge so a following access may raise it again
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  initial begin
    cyc(16);
    rstn <= 1'b1;
    cyc(1);
    rchk(DMACC_OPCR_OFF, 16'h0000);
    rchk(DMACC_CHANNEL_CONTROL_OFF0, 16'h0000);
    rchk(8'h30, 16'h0000);
    wreg(DMACC_OPCR_OFF, 16'hffff);
    rchk(DMACC_OPCR_OFF, 16'h0301);
    wreg(DMACC_OPCR_OFF, 16'h0001);
    wreg(DMACC_TCNT_OFF0, 16'h0002);
    wreg(DMACC_CHANNEL_CONTROL_OFF0, 16'h0025);
    cyc(6);
    chk(16'(gcnt[0]), 16'h0002);
    rchk(DMACC_CHANNEL_CONTROL_OFF0, 16'h0027);
    chk({12'h000, transfer_end_interrupt}, 16'h0001);
    rchk(DMACC_TCNT_OFF0, 16'h0000);
    wreg(DMACC_CHANNEL_CONTROL_OFF0, 16'h0027);
    wreg(DMACC_TCNT_OFF0, 16'h0003);
    cyc(4);
    chk(16'(gcnt[0]), 16'h0002);
    rchk(DMACC_CHANNEL_CONTROL_OFF0, 16'h0027);
    wreg(DMACC_CHANNEL_CONTROL_OFF0, 16'h0004);
    rchk(DMACC_CHANNEL_CONTROL_OFF0, 16'h0004);
    chk({12'h000, transfer_end_interrupt}, 16'h0000);
    wreg(DMACC_TCNT_OFF0 + DMACC_STEP_OFF, 16'h0002);
    wreg(DMACC_TCNT_OFF0 + 8'h08, 16'h0002);
    wreg(DMACC_CHANNEL_CONTROL_OFF0 + DMACC_STEP_OFF, 16'h0019);
    wreg(DMACC_CHANNEL_CONTROL_OFF0 + 8'h08, 16'h0001);
    cyc(3);
    chk(16'(gcnt[1] + gcnt[2]), 16'h0000);
    arm <= 1'b1;
    cyc(20);
    chk(16'(gcnt[1] * 16 + gcnt[2]), 16'h0022);
    chk({8'h00, unit_word, burst_mode}, 16'h0022);
    arm <= 1'b0;
    for (int e = 0; e < 2; e++) begin
      gcnt[0] = 0;
      wreg(DMACC_TCNT_OFF0, 16'h0005);
      wreg(DMACC_CHANNEL_CONTROL_OFF0, 16'h0021);
      cyc(1);
      if (e == 0) nmi <= 1'b1;
      else addr_error <= 1'b1;
      cyc(1);
      nmi <= 1'b0;
      addr_error <= 1'b0;
      cyc(8);
      chk(16'(gcnt[0] < 5), 16'h0001);
      rchk(DMACC_CHANNEL_CONTROL_OFF0, 16'h0021);
      rchk(DMACC_OPCR_OFF, e == 0 ? 16'h0003 : 16'h0005);
      wreg(DMACC_CHANNEL_CONTROL_OFF0, 16'h0020);
      wreg(DMACC_OPCR_OFF, 16'h0001);
      rchk(DMACC_OPCR_OFF, 16'h0001);
    end
    for (int m = 0; m < 4; m++) begin
      wreg(DMACC_OPCR_OFF, 16'h0000);
      rchk(DMACC_CHANNEL_CONTROL_OFF0, m ? 16'h0023 : 16'h0020);
      rchk(DMACC_CHANNEL_CONTROL_OFF0 + 8'h0c, m ? 16'h0023 : 16'h0000);
      wreg(DMACC_TCNT_OFF0, 16'h0001);
      wreg(DMACC_TCNT_OFF0 + 8'h0c, 16'h0001);
      wreg(DMACC_CHANNEL_CONTROL_OFF0, 16'h0021);
      wreg(DMACC_CHANNEL_CONTROL_OFF0 + 8'h0c, 16'h0021);
      first = 4'h0;
      wreg(DMACC_OPCR_OFF, 16'(m * 256 + 1));
      cyc(4);
      chk({12'h000, first}, (m == 1) ? 16'h0008 : 16'h0001);
    end
    standby <= 1'b1;
    cyc(1);
    standby <= 1'b0;
    rchk(DMACC_OPCR_OFF, 16'h0000);
    rchk(DMACC_CHANNEL_CONTROL_OFF0, 16'h0000);
    close_out();
  end
endmodule

// ===== testbench/dmacc_req_src.sv
// Request source model of a peripheral on the far side
`timescale 1ns/1ps
module dmacc_req_src #(parameter int GAP = 0) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic arm,
  input wire logic grant,
  output logic     req
);
  int wait_q;
  // Request is withdrawn one cycle after the first transfer is granted, so a second transfer is granted too
  always @(posedge clk) begin
    if (!rstn || !arm || grant) begin
      req <= 1'b0;
      wait_q <= GAP;
    end else if (wait_q > 0) wait_q <= wait_q - 1;
    else req <= 1'b1;
  end
endmodule
